//--- src/fsr_pkg.sv
package fsr_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WR_ARM = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PGM = 8'h02;
  localparam logic [7:0] OP_QPGM = 8'h38;
  localparam logic [7:0] OP_STAT = 8'h05;
  localparam logic [7:0] OP_CONF = 8'h15;
  localparam logic [7:0] OP_SECQ = 8'h2B;
  localparam logic [7:0] OP_SIG = 8'hAB;
  localparam logic [7:0] OP_RARM = 8'h66;
  localparam logic [7:0] OP_REXE = 8'h99;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOF = 8'h3B;
  localparam logic [7:0] OP_QOF = 8'h6B;
  localparam logic [7:0] OP_DIOF = 8'hBB;
  localparam logic [7:0] OP_QIOF = 8'hEB;
  localparam logic [7:0] OP_PTAB = 8'h5A;
  localparam logic [7:0] OP_IDQ = 8'h9F;
  localparam logic [7:0] OP_MDID = 8'h90;
  localparam logic [7:0] OP_OTPI = 8'hB1;
  localparam logic [7:0] OP_OTPO = 8'hC1;
  localparam logic [7:0] OP_BUR1 = 8'hC0;
  localparam logic [7:0] OP_BUR2 = 8'h77;
  localparam logic [7:0] OP_RES1 = 8'h7A;
  localparam logic [7:0] OP_RES2 = 8'h30;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_OPINFO = 8'h08;
  localparam int B_PERF = 0;
  localparam int B_CLR = 2;
  localparam int B_PLIM = 8;
  localparam int B_SEC_PSB = 2;
  localparam int B_SEC_ESB = 3;
  localparam logic [7:0] PLIM_RST = 8'h00;
  // ****************************************
  // Operation kinds and states
  // ****************************************
  localparam logic [1:0] K_PGM = 2'b00;
  localparam logic [1:0] K_E4 = 2'b01;
  localparam logic [1:0] K_E32 = 2'b10;
  localparam logic [1:0] K_E64 = 2'b11;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_SLAT = 3'b010,
    ST_SUSP = 3'b011,
    ST_REC = 3'b100
  } fsr_st_t;
  // First bytes of the parameter table
  localparam logic [63:0] PTAB = 64'hFF01010050444653;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int PSL_US = 20;
  localparam int ESL_US = 20;
  localparam int PRS_US = 100;
  localparam int ERS_US = 400;
  localparam int RSO_US = 20;
  localparam int RSP_US = 100;
  localparam int PGM_US = 1000;
  localparam int ERA_US = 10000;
  localparam int PSL_CYC = PSL_US * CLK_MHZ;
  localparam int ESL_CYC = ESL_US * CLK_MHZ;
  localparam int PRS_CYC = PRS_US * CLK_MHZ;
  localparam int ERS_CYC = ERS_US * CLK_MHZ;
  localparam int RSO_CYC = RSO_US * CLK_MHZ;
  localparam int RSP_CYC = RSP_US * CLK_MHZ;
  localparam int PGM_CYC = PGM_US * CLK_MHZ;
  localparam int ERA_CYC = ERA_US * CLK_MHZ;
endpackage : fsr_pkg

//--- src/fsr_core.sv
// Functional notes
// - suspend interrupts program or erase runs
// - latency, then clear latch, set flag
// - reads and queries accepted after latency
// - arm and programs only in erase suspend
// - status, reset, nop accepted without latency
// - suspend flags in security bits 2, 3
// - nested program only outside region, unprotected
// - nested program cannot be suspended
// - latch and busy high during nested program
// - resume sets latch, busy, clears flag
// - run on after resume; suspend gap
// - resume ignored in performance mode
// - any opcode but reset arm or reset execute cancels reset arming
// - reset executes only right after arming
// - software reset clears latch, suspend flags, fails, nested, otp, perf
// - software reset aborts running operation
// - longer recovery after interrupted program
// - table read: opcode, address, dummy, stream
// - suspended region reads back blocked
`timescale 1ns/1ps
`default_nettype none
module fsr_core #(
  parameter int PSL = fsr_pkg::PSL_CYC,
  parameter int ESL = fsr_pkg::ESL_CYC,
  parameter int PRS = fsr_pkg::PRS_CYC,
  parameter int ERS = fsr_pkg::ERS_CYC,
  parameter int RSO = fsr_pkg::RSO_CYC,
  parameter int RSP = fsr_pkg::RSP_CYC,
  parameter int PGMC = fsr_pkg::PGM_CYC,
  parameter int ERAC = fsr_pkg::ERA_CYC,
  parameter logic [7:0] OP_SUSP = 8'hB0,
  parameter logic [7:0] OP_E4 = 8'h20,
  parameter logic [7:0] OP_E32 = 8'h52,
  parameter logic [7:0] OP_E64 = 8'hD8,
  parameter logic [7:0] ID_BYTE = 8'h5C, // Arbitrary value
  parameter logic [7:0] SIG_BYTE = 8'h3A // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire logic cs_n, // Chip select pin
  input wire logic sclk, // Link clock pin
  input wire logic si, // Serial data in
  output logic so, // Serial data out
  output logic so_oe_n, // Output enable
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  output logic [31:0] hrdata // AHB read data
);
  // ****************************************
  // Checks and state
  // ****************************************
  localparam int CMAX = 2 ** 24;
  if (PGMC >= CMAX || ERAC >= CMAX || ERS >= CMAX || RSP >= CMAX || PGMC < 2 || ERAC < 2)
    $error("fsr_core counts out of range");

  typedef struct packed {
    logic [1:0] cs_y;
    logic [1:0] ck_y;
    logic [1:0] di_y;
    logic cs_d;
    logic ck_d;
    logic [2:0] bits;
    logic [2:0] bytes;
    logic [7:0] sh;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] dout;
    logic so;
    logic oe_n;
    logic ok;
    fsr_pkg::fsr_st_t st;
    logic [1:0] kind;
    logic [23:0] oaddr;
    logic [23:0] ocnt;
    logic [23:0] tm;
    logic np;
    logic [23:0] nadr;
    logic [23:0] ncnt;
    logic write_enable_latch;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic pfail;
    logic efail;
    logic armed;
    logic otp;
    logic perf;
    logic [7:0] plim;
    logic rblk;
    logic refd;
    logic hsl;
    logic hwr;
    logic [7:0] hadr;
    logic [31:0] rdat;
  } fsr_state_t;

  localparam fsr_state_t R0 = '{cs_y: 2'b11, cs_d: 1'b1, so: 1'b1, oe_n: 1'b1,
    st: fsr_pkg::ST_IDLE, plim: fsr_pkg::PLIM_RST, default: '0};

  fsr_state_t r;
  fsr_state_t n;
  logic rise;
  logic fall;
  logic csr;
  logic [7:0] b;
  logic do_res;
  logic do_rst;
  logic ld_blk;
  logic write_in_progress;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Same page, sector or block
  function automatic logic same(input logic [1:0] k, input logic [23:0] x,
                                input logic [23:0] y);
    case (k)
      fsr_pkg::K_PGM: same = (x[23:8] == y[23:8]);
      fsr_pkg::K_E4: same = (x[23:12] == y[23:12]);
      fsr_pkg::K_E32: same = (x[23:15] == y[23:15]);
      default: same = (x[23:16] == y[23:16]);
    endcase
  endfunction : same

  // Array read opcodes
  function automatic logic is_rd(input logic [7:0] c);
    is_rd = c == fsr_pkg::OP_READ || c == fsr_pkg::OP_FAST || c == fsr_pkg::OP_DOF ||
            c == fsr_pkg::OP_QOF || c == fsr_pkg::OP_DIOF || c == fsr_pkg::OP_QIOF;
  endfunction : is_rd

  // Header bytes before data out; 8 means no data
  function automatic logic [3:0] lead(input logic [7:0] c);
    case (c)
      fsr_pkg::OP_STAT, fsr_pkg::OP_CONF, fsr_pkg::OP_SECQ, fsr_pkg::OP_IDQ: lead = 4'h0;
      fsr_pkg::OP_READ, fsr_pkg::OP_SIG, fsr_pkg::OP_MDID: lead = 4'h3;
      fsr_pkg::OP_FAST, fsr_pkg::OP_PTAB, fsr_pkg::OP_DOF, fsr_pkg::OP_QOF: lead = 4'h4;
      fsr_pkg::OP_DIOF, fsr_pkg::OP_QIOF: lead = 4'h4;
      default: lead = 4'h8;
    endcase
  endfunction : lead

  // Command admission per operation state
  function automatic logic acc(input logic [7:0] c, input fsr_pkg::fsr_st_t s,
                               input logic e, input logic nested);
    logic t13;
    logic t12;
    logic ew;
    t13 = c == fsr_pkg::OP_WR_DIS || c == fsr_pkg::OP_STAT || c == fsr_pkg::OP_CONF ||
          c == fsr_pkg::OP_SECQ || c == fsr_pkg::OP_SIG || c == fsr_pkg::OP_RARM ||
          c == fsr_pkg::OP_REXE || c == fsr_pkg::OP_NOP;
    t12 = is_rd(c) || c == fsr_pkg::OP_PTAB || c == fsr_pkg::OP_IDQ ||
          c == fsr_pkg::OP_MDID || c == fsr_pkg::OP_OTPI || c == fsr_pkg::OP_OTPO ||
          c == fsr_pkg::OP_BUR1 || c == fsr_pkg::OP_BUR2 || c == fsr_pkg::OP_RES1 ||
          c == fsr_pkg::OP_RES2;
    ew = c == fsr_pkg::OP_WR_ARM || c == fsr_pkg::OP_PGM || c == fsr_pkg::OP_QPGM;
    case (s)
      fsr_pkg::ST_IDLE: acc = 1'b1;
      fsr_pkg::ST_RUN: acc = t13 || c == OP_SUSP;
      fsr_pkg::ST_SLAT: acc = t13;
      fsr_pkg::ST_SUSP: acc = t13 || (!nested && (t12 || (e && ew)));
      default: acc = 1'b0;
    endcase
  endfunction : acc

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    do_res = 1'b0;
    do_rst = 1'b0;
    ld_blk = 1'b0;
    b = {r.sh[6:0], r.di_y[1]};
    write_in_progress = r.st == fsr_pkg::ST_RUN || r.st == fsr_pkg::ST_SLAT || r.st == fsr_pkg::ST_REC || r.np;
    // Pin synchronisers and edge finders
    n.cs_y = {r.cs_y[0], cs_n};
    n.ck_y = {r.ck_y[0], sclk};
    n.di_y = {r.di_y[0], si};
    n.cs_d = r.cs_y[1];
    n.ck_d = r.ck_y[1];
    rise = r.ck_y[1] && !r.ck_d;
    fall = !r.ck_y[1] && r.ck_d;
    csr = r.cs_y[1] && !r.cs_d;
    // Software register write, clears before sets
    if (r.hsl && r.hwr && r.hadr == fsr_pkg::A_CTRL) begin
      n.perf = hwdata[fsr_pkg::B_PERF];
      n.plim = hwdata[fsr_pkg::B_PLIM +: 8];
      if (hwdata[fsr_pkg::B_CLR]) begin
        n.rblk = 1'b0;
        n.refd = 1'b0;
      end
    end
    // Operation engine
    case (r.st)
      fsr_pkg::ST_RUN: begin
        if (r.tm != 24'h000000) n.tm = r.tm - 24'h000001;
        if (r.ocnt <= 24'h000001) begin
          n.st = fsr_pkg::ST_IDLE;
          n.write_enable_latch = 1'b0;
        end else begin
          n.ocnt = r.ocnt - 24'h000001;
        end
      end
      fsr_pkg::ST_SLAT: begin
        if (r.tm <= 24'h000001) begin
          n.st = fsr_pkg::ST_SUSP;
          n.write_enable_latch = 1'b0;
          if (r.kind == fsr_pkg::K_PGM) n.program_suspended_flag = 1'b1;
          else n.erase_suspended_flag = 1'b1;
        end else begin
          n.tm = r.tm - 24'h000001;
        end
      end
      fsr_pkg::ST_REC: begin
        if (r.tm <= 24'h000001) n.st = fsr_pkg::ST_IDLE;
        else n.tm = r.tm - 24'h000001;
      end
      default: ;
    endcase
    // Nested program inside an erase suspend
    if (r.np) begin
      if (r.ncnt <= 24'h000001) begin
        n.np = 1'b0;
        n.write_enable_latch = 1'b0;
      end else begin
        n.ncnt = r.ncnt - 24'h000001;
      end
    end
    // Serial frame handling
    if (r.cs_y[1]) begin
      n.bits = 3'h0;
      n.bytes = 3'h0;
      n.oe_n = 1'b1;
      n.ok = 1'b0;
    end else begin
      if (rise) begin
        n.sh = b;
        n.bits = r.bits + 3'h1;
        if (r.bits == 3'h7) begin
          if (r.bytes == 3'h0) begin
            n.op = b;
            n.ok = acc(b, r.st, r.erase_suspended_flag, r.np);
            if (!n.ok) n.refd = 1'b1;
            if (b != fsr_pkg::OP_RARM && b != fsr_pkg::OP_REXE) n.armed = 1'b0;
          end else if (r.bytes < 3'h4) begin
            n.addr = {r.addr[15:0], b};
          end
          if (r.bytes != 3'h7) n.bytes = r.bytes + 3'h1;
          if (n.ok && {1'b0, r.bytes} >= lead(n.op)) begin
            n.oe_n = 1'b0;
            n.addr = n.addr + 24'h000001;
            case (n.op)
              fsr_pkg::OP_STAT: n.dout = {6'h00, r.write_enable_latch, write_in_progress};
              fsr_pkg::OP_SECQ: begin
                n.dout = 8'h00;
                n.dout[fsr_pkg::B_SEC_PSB] = r.program_suspended_flag;
                n.dout[fsr_pkg::B_SEC_ESB] = r.erase_suspended_flag;
                n.dout[5] = r.pfail;
                n.dout[6] = r.efail;
              end
              fsr_pkg::OP_IDQ, fsr_pkg::OP_MDID: n.dout = ID_BYTE;
              fsr_pkg::OP_SIG: n.dout = SIG_BYTE;
              fsr_pkg::OP_PTAB: begin
                if (r.addr[23:3] == 21'h000000) n.dout = fsr_pkg::PTAB[{r.addr[2:0], 3'h0} +: 8];
                else n.dout = 8'hFF;
              end
              default: begin
                ld_blk = ((r.program_suspended_flag || r.erase_suspended_flag) && same(r.kind, r.oaddr, n.addr - 24'h000001)) ||
                         (r.np && same(fsr_pkg::K_PGM, r.nadr, n.addr - 24'h000001));
                n.dout = (is_rd(n.op) && !ld_blk) ? 8'hFF : 8'h00;
                if (ld_blk) n.rblk = 1'b1;
              end
            endcase
          end
        end
      end
      if (fall && !r.oe_n) begin
        n.so = r.dout[7];
        n.dout = {r.dout[6:0], 1'b1};
      end
    end
    // Commands executed as chip select rises
    if (csr && r.ok && r.bits == 3'h0) begin
      case (r.op)
        fsr_pkg::OP_WR_ARM: n.write_enable_latch = 1'b1;
        fsr_pkg::OP_WR_DIS: if (!r.np) n.write_enable_latch = 1'b0;
        fsr_pkg::OP_PGM, fsr_pkg::OP_QPGM: begin
          if (r.write_enable_latch && r.bytes >= 3'h4) begin
            n.write_enable_latch = 1'b0;
            if (r.addr[23:16] < r.plim || (r.erase_suspended_flag && same(r.kind, r.oaddr, r.addr))) begin
              n.pfail = 1'b1;
            end else if (r.st == fsr_pkg::ST_SUSP) begin
              n.np = 1'b1;
              n.write_enable_latch = 1'b1;
              n.nadr = r.addr;
              n.ncnt = 24'(PGMC);
              n.pfail = 1'b0;
            end else begin
              n.st = fsr_pkg::ST_RUN;
              n.write_enable_latch = 1'b1;
              n.kind = fsr_pkg::K_PGM;
              n.oaddr = r.addr;
              n.ocnt = 24'(PGMC);
              n.tm = 24'h000000;
              n.pfail = 1'b0;
            end
          end
        end
        OP_E4, OP_E32, OP_E64: begin
          if (r.write_enable_latch && r.bytes >= 3'h4 && r.st == fsr_pkg::ST_IDLE) begin
            if (r.addr[23:16] < r.plim) begin
              n.efail = 1'b1;
              n.write_enable_latch = 1'b0;
            end else begin
              n.st = fsr_pkg::ST_RUN;
              n.kind = (r.op == OP_E4) ? fsr_pkg::K_E4 :
                       (r.op == OP_E32) ? fsr_pkg::K_E32 : fsr_pkg::K_E64;
              n.oaddr = r.addr;
              n.ocnt = 24'(ERAC);
              n.tm = 24'h000000;
              n.efail = 1'b0;
            end
          end
        end
        OP_SUSP: begin
          if (r.st == fsr_pkg::ST_RUN && r.tm == 24'h000000) begin
            n.st = fsr_pkg::ST_SLAT;
            n.tm = (r.kind == fsr_pkg::K_PGM) ? 24'(PSL) : 24'(ESL);
          end
        end
        fsr_pkg::OP_RES1, fsr_pkg::OP_RES2: begin
          if (r.st == fsr_pkg::ST_SUSP && !r.perf && !r.np) begin
            do_res = 1'b1;
            n.st = fsr_pkg::ST_RUN;
            n.write_enable_latch = 1'b1;
            n.program_suspended_flag = 1'b0;
            n.erase_suspended_flag = 1'b0;
            n.tm = (r.kind == fsr_pkg::K_PGM) ? 24'(PRS) : 24'(ERS);
          end
        end
        fsr_pkg::OP_OTPI: n.otp = 1'b1;
        fsr_pkg::OP_OTPO: n.otp = 1'b0;
        fsr_pkg::OP_RARM: n.armed = 1'b1;
        fsr_pkg::OP_REXE: begin
          n.armed = 1'b0;
          if (r.armed) begin
            do_rst = 1'b1;
            n.st = fsr_pkg::ST_REC;
            n.tm = ((r.st != fsr_pkg::ST_IDLE && r.kind == fsr_pkg::K_PGM) || r.np) ?
                   24'(RSP) : 24'(RSO);
            {n.write_enable_latch, n.program_suspended_flag, n.erase_suspended_flag, n.pfail, n.efail, n.np, n.otp, n.perf} = 8'h00;
          end
        end
        default: ;
      endcase
    end
    // Bus slave address phase and read data
    n.hsl = hsel && htrans[1] && hready;
    n.hwr = hwrite;
    n.hadr = haddr[7:0];
    if (n.hsl && !hwrite) begin
      case (haddr[7:0])
        fsr_pkg::A_STATUS: n.rdat = {8'h00, r.op, 5'h00, r.st == fsr_pkg::ST_REC, n.refd,
          n.rblk, r.efail, r.pfail, r.armed, r.np, r.erase_suspended_flag, r.program_suspended_flag, r.write_enable_latch, write_in_progress};
        fsr_pkg::A_CTRL: n.rdat = {16'h0000, n.plim, 7'h00, n.perf};
        fsr_pkg::A_OPINFO: n.rdat = {2'h0, r.st, r.otp, r.kind, r.oaddr};
        default: n.rdat = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) r <= R0;
    else r <= n;
  end

  // Outputs
  assign so = r.so;
  assign so_oe_n = r.oe_n;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdat;

  // ****************************************
  // Assertions
  // ****************************************
  property p_lat;
    @(posedge clk) disable iff (reset)
    (r.st == fsr_pkg::ST_SLAT && r.tm <= 24'h000001 && !do_rst) |=>
      (r.st == fsr_pkg::ST_SUSP && !r.write_enable_latch);
  endproperty
  a_lat: assert property (p_lat) else $error("suspend latency end wrong");

  property p_flag;
    @(posedge clk) disable iff (reset)
    $rose(r.program_suspended_flag) |-> $past(r.st) == fsr_pkg::ST_SLAT && r.kind == fsr_pkg::K_PGM;
  endproperty
  a_flag: assert property (p_flag) else $error("program flag set wrongly");

  property p_res;
    @(posedge clk) disable iff (reset)
    do_res |=> r.write_enable_latch && r.st == fsr_pkg::ST_RUN && !r.program_suspended_flag && !r.erase_suspended_flag;
  endproperty
  a_res: assert property (p_res) else $error("resume effects missing");

  property p_perf;
    @(posedge clk) disable iff (reset)
    (csr && r.ok && r.perf && r.st == fsr_pkg::ST_SUSP &&
     (r.op == fsr_pkg::OP_RES1 || r.op == fsr_pkg::OP_RES2)) |=> r.st == fsr_pkg::ST_SUSP;
  endproperty
  a_perf: assert property (p_perf) else $error("resume taken in perf mode");

  property p_nest;
    @(posedge clk) disable iff (reset)
    r.np |-> r.write_enable_latch && write_in_progress && r.st == fsr_pkg::ST_SUSP;
  endproperty
  a_nest: assert property (p_nest) else $error("nested program bits wrong");

  property p_rst;
    @(posedge clk) disable iff (reset)
    do_rst |=> r.st == fsr_pkg::ST_REC && !r.write_enable_latch && !r.program_suspended_flag && !r.erase_suspended_flag && !r.np && !r.perf;
  endproperty
  a_rst: assert property (p_rst) else $error("software reset incomplete");

  property p_arm;
    @(posedge clk) disable iff (reset)
    (rise && !r.cs_y[1] && r.bits == 3'h7 && r.bytes == 3'h0 &&
     b != fsr_pkg::OP_RARM && b != fsr_pkg::OP_REXE) |=> !r.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("reset arming survived");

  property p_blk;
    @(posedge clk) disable iff (reset)
    ld_blk |=> r.dout == 8'h00 && r.rblk;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked region read out");

  property p_gap;
    @(posedge clk) disable iff (reset)
    (csr && r.ok && r.op == OP_SUSP && r.tm != 24'h000000) |=> r.st != fsr_pkg::ST_SLAT;
  endproperty
  a_gap: assert property (p_gap) else $error("suspend inside resume gap");
endmodule : fsr_core
`default_nettype wire

//--- verification/fsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host serial controller model
// ****************************************
module fsr_host_model (
  output var logic cs_n, // Chip select
  output var logic sclk, // Link clock
  output var logic si, // Data to device
  input wire logic so // Data from device
);
  // Idle lines: select high, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // One frame: header bytes out, then an optional byte in
  task automatic frame(input logic [39:0] hdr, input int nb, input bit rd_on,
                       output logic [7:0] rd);
    rd = 8'h00;
    #37 cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      si = hdr[39 - i];
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    for (int i = 0; i < (rd_on ? 8 : 0); i++) begin
      #200 sclk = 1'b1;
      rd = {rd[6:0], so};
      #200 sclk = 1'b0;
    end
    #200 cs_n = 1'b1;
    si = ~si; // Released line shows no stale value
    #600;
  endtask : frame
endmodule : fsr_host_model
`default_nettype wire

//--- verification/flash_suspend_resume_reset_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_reset_tb_top;
  localparam logic [7:0] AS = fsr_pkg::A_STATUS;
  localparam logic [7:0] AC = fsr_pkg::A_CTRL;
  localparam logic [7:0] AO = fsr_pkg::A_OPINFO;
  logic clk, reset, cs_n, sclk, si, so, so_oe_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rb;
  int fails, compares, cyc;
  // ****************************************
  // Design and host
  // ****************************************
  fsr_core #(.PSL(200), .ESL(200), .RSP(400),
    .PGMC(2000), .ERAC(2000)) dut (.clk(clk), .reset(reset), .cs_n(cs_n),
    .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  fsr_host_model host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task end_of_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Single AHB word transfer, address then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdw = hrdata;
  endtask : ahb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000);
    chk(rdw & m, e);
  endtask : rchk
  task automatic f(input logic [39:0] h, input int nb, input bit r);
    host.frame(h, nb, r, rb);
    chk({31'h00000000, so_oe_n}, 32'h00000001);
  endtask : f
  task automatic op1(input logic [7:0] o);
    f({o, 32'h00000000}, 1, 1'b0);
  endtask : op1
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    fails = 0;
    compares = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset values and unmapped word
    for (int a = 0; a < 16; a += 4) rchk(a[7:0], 32'hFFFFFFFF, 32'h00000000);
    // Sector erase, then suspend; read refused inside the suspend latency
    op1(8'h06);
    rchk(AS, 32'h00000003, 32'h00000002);
    f({8'h20, 24'h100000, 8'h00}, 4, 1'b0);
    rchk(AS, 32'h00000001, 32'h00000001);
    op1(8'hB0);
    rchk(AO, 32'h38000000, 32'h10000000);
    rchk(AS, 32'h0000000A, 32'h00000002);
    f({8'h03, 24'h200000, 8'h00}, 4, 1'b1);
    rchk(AS, 32'h00000200, 32'h00000200);
    rchk(AS, 32'h0000000E, 32'h00000008);
    f({8'h2B, 32'h00000000}, 1, 1'b1);
    chk({24'h000000, rb & 8'h0C}, 32'h00000008);
    f({8'h03, 24'h100010, 8'h00}, 4, 1'b1);
    chk({24'h000000, rb}, 32'h00000000);
    rchk(AS, 32'h00000100, 32'h00000100);
    f({8'h03, 24'h200000, 8'h00}, 4, 1'b1);
    chk({24'h000000, rb}, 32'h000000FF);
    ahb(1'b1, AC, 32'h00000004);
    // Program inside the suspended sector fails
    op1(8'h06);
    f({8'h02, 24'h100020, 8'h00}, 4, 1'b0);
    rchk(AS, 32'h00000052, 32'h00000040);
    // Nested program elsewhere runs and cannot be suspended
    op1(8'h06);
    f({8'h02, 24'h300000, 8'h00}, 4, 1'b0);
    rchk(AS, 32'h00000013, 32'h00000013);
    op1(8'hB0);
    rchk(AS, 32'h0000021C, 32'h00000218);
    ahb(1'b1, AC, 32'h00000004);
    f({8'h05, 32'h00000000}, 1, 1'b1);
    chk({24'h000000, rb}, 32'h00000003);
    rchk(AS, 32'h00000200, 32'h00000000);
    f({8'h03, 24'h200000, 8'h00}, 4, 1'b1);
    rchk(AS, 32'h00000200, 32'h00000200);
    repeat (2100) @(posedge clk);
    rchk(AS, 32'h0000001B, 32'h00000008);
    // Resume ignored in performance mode, then taken
    ahb(1'b1, AC, 32'h00000005);
    op1(8'h7A);
    rchk(AS, 32'h00000008, 32'h00000008);
    ahb(1'b1, AC, 32'h00000004);
    op1(8'h30);
    rchk(AS, 32'h0000000B, 32'h00000003);
    op1(8'hB0);
    rchk(AO, 32'h38000000, 32'h08000000);
    repeat (2200) @(posedge clk);
    rchk(AS, 32'h0000001F, 32'h00000000);
    // Program suspend
    op1(8'h06);
    f({8'h02, 24'h050000, 8'h00}, 4, 1'b0);
    repeat (450) @(posedge clk);
    op1(8'hB0);
    repeat (250) @(posedge clk);
    rchk(AS, 32'h0000000E, 32'h00000004);
    ahb(1'b1, AC, 32'h00000004);
    op1(8'h06);
    rchk(AS, 32'h00000202, 32'h00000200);
    f({8'h20, 32'h00000000}, 4, 1'b0);
    rchk(AO, 32'h3BFFFFFF, 32'h18050000);
    // Parameter table read while suspended
    f({8'h5A, 32'h00000000}, 5, 1'b1);
    chk({24'h000000, rb}, 32'h00000053);
    f({8'h5A, 24'h000003, 8'h00}, 5, 1'b1);
    chk({24'h000000, rb}, 32'h00000050);
    // Arming cancelled, then a real software reset
    op1(8'h66);
    rchk(AS, 32'h00000020, 32'h00000020);
    op1(8'h00);
    rchk(AS, 32'h00000020, 32'h00000000);
    op1(8'h99);
    rchk(AS, 32'h00000004, 32'h00000004);
    op1(8'h66);
    op1(8'h99);
    rchk(AO, 32'h38000000, 32'h20000000);
    repeat (100) @(posedge clk);
    rchk(AS, 32'h00000400, 32'h00000400);
    repeat (400) @(posedge clk);
    rchk(AS, 32'h000004FF, 32'h00000000);
    rchk(AO, 32'h3C000000, 32'h00000000);
    end_of_test();
  end
endmodule : flash_suspend_resume_reset_tb_top
`default_nettype wire
